// ### nhi_pkg.sv
/*
 Package for the host instruction decoder: command codes, field sizes,
 status codes and the decoded-parameter structs.
 Assumes a byte stream from the host port framed by a start-of-instruction strobe.
*/
package nhi_pkg;
    localparam logic [7:0]  CMD_SWITCH_MODE    = 8'h0b;
    localparam logic [7:0]  CMD_CARD_AUTH      = 8'h0c;
    localparam logic [7:0]  CMD_TAG_INVENTORY  = 8'h0d;
    localparam logic [7:0]  MODE_LISTEN        = 8'h02;
    localparam logic [7:0]  KEY_TYPE_A         = 8'h60;
    localparam logic [7:0]  KEY_TYPE_B         = 8'h61;
    localparam logic [7:0]  STATUS_OK          = 8'h00;
    localparam logic [7:0]  STATUS_DENIED      = 8'h01;
    localparam logic [7:0]  STATUS_TIMEOUT     = 8'h02;
    localparam logic [7:0]  SUBMODE_END        = 8'h00;
    localparam logic [7:0]  SUBMODE_STANDBY    = 8'h01;
    localparam logic [7:0]  SUBMODE_NO_STANDBY = 8'h02;
    localparam logic [7:0]  SLOT_ALL           = 8'h00;
    localparam logic [7:0]  SLOT_ONE           = 8'h01;
    localparam logic [7:0]  SLOT_ONE_HANDLE    = 8'h02;
    localparam logic [7:0]  SELECT_MAX         = 8'h27;
    localparam logic [3:0]  KEY_BYTES          = 4'h6;
    localparam logic [3:0]  UID_BYTES          = 4'h4;
    localparam logic [3:0]  ROUND_BYTES        = 4'h3;
    localparam logic [15:0] WAKE_MAX_MS        = 16'h0a82;
    localparam logic [15:0] CRC16_INIT         = 16'hffff;
    localparam logic [15:0] CRC16_POLY         = 16'h1021;
    localparam logic [4:0]  CRC5_INIT          = 5'h09;
    localparam logic [4:0]  CRC5_POLY          = 5'h09;
    localparam logic [2:0]  VALID_ALL          = 3'h0;

    typedef struct packed {
        logic [47:0] key;
        logic        use_key_b;
        logic [7:0]  block;
        logic [31:0] uid;
    } nhi_auth_t;

    typedef struct packed {
        logic [7:0] tech_mask;
        logic       stop_no_field;
        logic       standby_no_field;
    } nhi_listen_t;

    typedef struct packed {
        logic        with_select;
        logic [5:0]  select_len;
        logic [2:0]  last_bits;
        logic [15:0] select_crc;
        logic [23:0] round;
        logic [4:0]  round_crc;
        logic        all_slots;
        logic        want_handle;
    } nhi_inv_t;
endpackage

// ### nhi_decoder.sv
/*
 Host instruction decoder for card listen, key authentication and tag inventory.
 Assumes the host port delivers whole bytes on the same clock with a start strobe,
 and that the RF engine answers starts with done and a result status.
*/
// What this block does
// - Listen only for technologies in mask.
// - Sub-mode zero ends listening without field.
// - Sub-mode one standby, two never standby.
// - Authenticate: key, type, block, UID; status.
// - Key type codes select key A/B.
// - Any block address byte accepted.
// - Status zero ok, one denied, two timeout.
// - Second general timer reserved during authentication.
// - Inventory length byte, zero means no Select.
// - Valid bits zero sends whole last byte.
// - Timeslot byte selects all, one, one+handle.
`timescale 1ns/1ps
module nhi_decoder
(
    input  wire logic               clock,
    input  wire logic               reset_n,
    input  wire logic               host_start,
    input  wire logic               host_valid,
    input  wire logic [7:0]         host_byte,
    input  wire logic               rf_field,
    input  wire logic               rf_done,
    input  wire logic [1:0]         rf_result,
    output logic                    listen_active,
    output logic                    listen_standby,
    output nhi_pkg::nhi_listen_t    listen_cfg,
    output logic                    listen_end_irq,
    output logic                    auth_start,
    output nhi_pkg::nhi_auth_t      auth_cfg,
    output logic                    second_general_timer_reserved,
    output logic                    status_valid,
    output logic [7:0]              status_byte,
    output logic                    inv_start,
    output nhi_pkg::nhi_inv_t       inv_cfg,
    output logic                    select_byte_valid,
    output logic [7:0]              select_byte,
    output logic                    cmd_invalid
);
    // ==========================================================
    // CRC helpers
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (r[15] ^ d[i]) ? ((r << 1) ^ nhi_pkg::CRC16_POLY) : (r << 1);
        return r;
    endfunction

    function automatic logic [4:0] crc5_byte(input logic [4:0] c, input logic [7:0] d);
        logic [4:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (r[4] ^ d[i]) ? ((r << 1) ^ nhi_pkg::CRC5_POLY) : (r << 1);
        return r;
    endfunction

    // ==========================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ==========================================================
    // Field pin synchroniser
    logic [2:0] field_sync_reg;
    logic       field_reg;
    logic       field_next;
    always_comb
    begin
        field_next = field_reg;
        if (field_sync_reg[1] == field_sync_reg[2])
            field_next = field_sync_reg[2];
    end

    // ==========================================================
    // Instruction parser
    typedef enum logic [3:0] {
        ST_CMD, ST_MODE, ST_TECH, ST_SUB, ST_LISTEN,
        ST_KEY, ST_KTYPE, ST_BLOCK, ST_UID, ST_AUTH,
        ST_SLEN, ST_VBITS, ST_SEL, ST_ROUND, ST_SLOT, ST_SKIP
    } nhi_state_t;

    nhi_state_t          state_reg, state_next;
    logic [3:0]          cnt_reg, cnt_next;
    logic [5:0]          sel_cnt_reg, sel_cnt_next;
    nhi_pkg::nhi_listen_t lcfg_reg, lcfg_next;
    nhi_pkg::nhi_auth_t  acfg_reg, acfg_next;
    nhi_pkg::nhi_inv_t   icfg_reg, icfg_next;
    logic                lact_reg, lact_next;
    logic                lsb_reg, lsb_next;
    logic                lirq_reg, lirq_next;
    logic                ast_reg, ast_next;
    logic                t2_reg, t2_next;
    logic                sv_reg, sv_next;
    logic [7:0]          sb_reg, sb_next;
    logic                ist_reg, ist_next;
    logic                selv_reg, selv_next;
    logic [7:0]          selb_reg, selb_next;
    logic                inv_reg, inv_next;

    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        sel_cnt_next = sel_cnt_reg;
        lcfg_next    = lcfg_reg;
        acfg_next    = acfg_reg;
        icfg_next    = icfg_reg;
        lact_next    = lact_reg;
        lsb_next     = lsb_reg;
        lirq_next    = 1'b0;
        ast_next     = 1'b0;
        t2_next      = t2_reg;
        sv_next      = 1'b0;
        sb_next      = sb_reg;
        ist_next     = 1'b0;
        selv_next    = 1'b0;
        selb_next    = selb_reg;
        inv_next     = 1'b0;
        if (host_start && state_reg != ST_LISTEN && state_reg != ST_AUTH)
        begin
            state_next = ST_CMD;
        end
        else if (host_valid)
        begin
            case (state_reg)
                ST_CMD:
                begin
                    cnt_next = 4'h0;
                    icfg_next.select_crc = nhi_pkg::CRC16_INIT;
                    icfg_next.round_crc  = nhi_pkg::CRC5_INIT;
                    case (host_byte)
                        nhi_pkg::CMD_SWITCH_MODE:   state_next = ST_MODE;
                        nhi_pkg::CMD_CARD_AUTH:     state_next = ST_KEY;
                        nhi_pkg::CMD_TAG_INVENTORY: state_next = ST_SLEN;
                        default:                    state_next = ST_SKIP;
                    endcase
                end
                ST_MODE:
                    state_next = (host_byte == nhi_pkg::MODE_LISTEN) ? ST_TECH : ST_SKIP;
                ST_TECH:
                begin
                    lcfg_next.tech_mask = host_byte;
                    state_next = ST_SUB;
                end
                ST_SUB:
                begin
                    lcfg_next.stop_no_field    = (host_byte == nhi_pkg::SUBMODE_END);
                    lcfg_next.standby_no_field = (host_byte == nhi_pkg::SUBMODE_STANDBY);
                    if (host_byte > nhi_pkg::SUBMODE_NO_STANDBY)
                    begin
                        inv_next   = 1'b1;
                        state_next = ST_SKIP;
                    end
                    else
                    begin
                        lact_next  = 1'b1;
                        state_next = ST_LISTEN;
                    end
                end
                ST_KEY:
                begin
                    acfg_next.key = {acfg_reg.key[39:0], host_byte};
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == nhi_pkg::KEY_BYTES - 4'h1)
                        state_next = ST_KTYPE;
                end
                ST_KTYPE:
                begin
                    // code picks key A or B
                    acfg_next.use_key_b = (host_byte == nhi_pkg::KEY_TYPE_B);
                    cnt_next = 4'h0;
                    if (host_byte != nhi_pkg::KEY_TYPE_A && host_byte != nhi_pkg::KEY_TYPE_B)
                    begin
                        inv_next   = 1'b1;
                        state_next = ST_SKIP;
                    end
                    else
                        state_next = ST_BLOCK;
                end
                ST_BLOCK:
                begin
                    acfg_next.block = host_byte;
                    state_next = ST_UID;
                end
                ST_UID:
                begin
                    acfg_next.uid = {acfg_reg.uid[23:0], host_byte};
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == nhi_pkg::UID_BYTES - 4'h1)
                    begin
                        ast_next   = 1'b1;
                        t2_next    = 1'b1;
                        state_next = ST_AUTH;
                    end
                end
                ST_SLEN:
                begin
                    icfg_next.with_select = (host_byte != 8'h00);
                    icfg_next.select_len  = host_byte[5:0];
                    icfg_next.last_bits   = nhi_pkg::VALID_ALL;
                    sel_cnt_next = 6'h00;
                    if (host_byte > nhi_pkg::SELECT_MAX)
                    begin
                        inv_next   = 1'b1;
                        state_next = ST_SKIP;
                    end
                    else
                        state_next = (host_byte == 8'h00) ? ST_ROUND : ST_VBITS;
                end
                ST_VBITS:
                begin
                    icfg_next.last_bits = host_byte[2:0];
                    state_next = ST_SEL;
                end
                ST_SEL:
                begin
                    selv_next = 1'b1;
                    selb_next = host_byte;
                    icfg_next.select_crc = crc16_byte(icfg_reg.select_crc, host_byte);
                    sel_cnt_next = sel_cnt_reg + 6'h01;
                    if (sel_cnt_reg + 6'h01 == icfg_reg.select_len)
                        state_next = ST_ROUND;
                end
                ST_ROUND:
                begin
                    icfg_next.round = {icfg_reg.round[15:0], host_byte};
                    icfg_next.round_crc = crc5_byte(icfg_reg.round_crc, host_byte);
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == nhi_pkg::ROUND_BYTES - 4'h1)
                        state_next = ST_SLOT;
                end
                ST_SLOT:
                begin
                    icfg_next.all_slots   = (host_byte == nhi_pkg::SLOT_ALL);
                    icfg_next.want_handle = (host_byte == nhi_pkg::SLOT_ONE_HANDLE);
                    if (host_byte > nhi_pkg::SLOT_ONE_HANDLE)
                        inv_next = 1'b1;
                    else
                        ist_next = 1'b1;
                    state_next = ST_SKIP;
                end
                default:
                    state_next = state_reg;
            endcase
        end
        if (state_reg == ST_LISTEN)
        begin
            if (!field_reg && lcfg_reg.stop_no_field)
            begin
                lact_next  = 1'b0;
                lsb_next   = 1'b0;
                lirq_next  = 1'b1;
                state_next = ST_SKIP;
            end
            else
                lsb_next = !field_reg && lcfg_reg.standby_no_field;
        end
        if (state_reg == ST_AUTH && rf_done)
        begin
            case (rf_result)
                2'h0:    sb_next = nhi_pkg::STATUS_OK;
                2'h1:    sb_next = nhi_pkg::STATUS_DENIED;
                default: sb_next = nhi_pkg::STATUS_TIMEOUT;
            endcase
            sv_next    = 1'b1;
            t2_next    = 1'b0;
            state_next = ST_SKIP;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            field_sync_reg <= 3'h0;
            field_reg      <= 1'b0;
            state_reg      <= ST_SKIP;
            cnt_reg        <= 4'h0;
            sel_cnt_reg    <= 6'h00;
            lcfg_reg       <= '0;
            acfg_reg       <= '0;
            icfg_reg       <= '0;
            lact_reg       <= 1'b0;
            lsb_reg        <= 1'b0;
            lirq_reg       <= 1'b0;
            ast_reg        <= 1'b0;
            t2_reg         <= 1'b0;
            sv_reg         <= 1'b0;
            sb_reg         <= 8'h00;
            ist_reg        <= 1'b0;
            selv_reg       <= 1'b0;
            selb_reg       <= 8'h00;
            inv_reg        <= 1'b0;
        end
        else
        begin
            field_sync_reg <= {field_sync_reg[1:0], rf_field};
            field_reg      <= field_next;
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            sel_cnt_reg    <= sel_cnt_next;
            lcfg_reg       <= lcfg_next;
            acfg_reg       <= acfg_next;
            icfg_reg       <= icfg_next;
            lact_reg       <= lact_next;
            lsb_reg        <= lsb_next;
            lirq_reg       <= lirq_next;
            ast_reg        <= ast_next;
            t2_reg         <= t2_next;
            sv_reg         <= sv_next;
            sb_reg         <= sb_next;
            ist_reg        <= ist_next;
            selv_reg       <= selv_next;
            selb_reg       <= selb_next;
            inv_reg        <= inv_next;
        end
    end

    // ==========================================================
    // Outputs
    assign listen_active     = lact_reg;
    assign listen_standby    = lsb_reg;
    assign listen_cfg        = lcfg_reg;
    assign listen_end_irq    = lirq_reg;
    assign auth_start        = ast_reg;
    assign auth_cfg          = acfg_reg;
    assign second_general_timer_reserved   = t2_reg;
    assign status_valid      = sv_reg;
    assign status_byte       = sb_reg;
    assign inv_start         = ist_reg;
    assign inv_cfg           = icfg_reg;
    assign select_byte_valid = selv_reg;
    assign select_byte       = selb_reg;
    assign cmd_invalid       = inv_reg;
endmodule

// ### nhi_decoder_props.sv
/*
 Port checker for the host instruction decoder.
 Assumes it is bound to nhi_decoder and sees only its ports.
*/
`timescale 1ns/1ps
module nhi_decoder_props
(
    input wire logic                 clock,
    input wire logic                 reset_n,
    input wire logic                 rf_field,
    input wire logic                 rf_done,
    input wire logic [1:0]           rf_result,
    input wire logic                 listen_active,
    input wire logic                 listen_standby,
    input wire nhi_pkg::nhi_listen_t listen_cfg,
    input wire logic                 listen_end_irq,
    input wire logic                 auth_start,
    input wire logic                 second_general_timer_reserved,
    input wire logic                 status_valid,
    input wire logic [7:0]           status_byte,
    input wire logic                 inv_start,
    input wire nhi_pkg::nhi_inv_t    inv_cfg,
    input wire logic                 cmd_invalid
);
    // ==========================================
    // Assertions on the decoder outputs.
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    property p_status_code;
        rf_done && second_general_timer_reserved |=> status_valid && status_byte == ($past(rf_result) == 2'h0 ? nhi_pkg::STATUS_OK :
            $past(rf_result) == 2'h1 ? nhi_pkg::STATUS_DENIED : nhi_pkg::STATUS_TIMEOUT);
    endproperty
    a_status_code: assert property (p_status_code) else $error("status byte wrong");
    property p_status_cause;
        status_valid |-> $past(rf_done) && $past(second_general_timer_reserved);
    endproperty
    a_status_cause: assert property (p_status_cause) else $error("status without authentication");
    property p_timer_start;
        auth_start |-> ##[0:1] second_general_timer_reserved;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer not reserved");
    property p_timer_hold;
        second_general_timer_reserved && !rf_done && !status_valid |=> second_general_timer_reserved;
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer released early");
    property p_refuse;
        cmd_invalid |=> !auth_start && !inv_start;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused instruction started");
    property p_listen_end;
        listen_active && listen_cfg.stop_no_field && !rf_field |-> ##[1:8] !listen_active;
    endproperty
    a_listen_end: assert property (p_listen_end) else $error("listen did not end");
    property p_standby;
        listen_standby |-> listen_active && listen_cfg.standby_no_field;
    endproperty
    a_standby: assert property (p_standby) else $error("standby in wrong sub-mode");
    property p_inv_select;
        inv_start |-> inv_cfg.with_select == (inv_cfg.select_len != 6'h00);
    endproperty
    a_inv_select: assert property (p_inv_select) else $error("select flag wrong");
    c_auth: cover property (auth_start);
    c_inv: cover property (inv_start && inv_cfg.with_select);
    c_end: cover property (listen_end_irq);
endmodule

bind nhi_decoder nhi_decoder_props u_props
(
    .clock, .reset_n, .rf_field, .rf_done, .rf_result, .listen_active, .listen_standby, .listen_cfg,
    .listen_end_irq, .auth_start, .second_general_timer_reserved, .status_valid, .status_byte, .inv_start, .inv_cfg, .cmd_invalid
);

// ### nhi_host_model.sv
/*
 Host model that issues instructions to the decoder.
 Assumes the decoder takes bytes on the rising clock edge.
*/
`timescale 1ns/1ps
module nhi_host_model
(
    input  wire logic  clock,
    output logic       host_start,
    output logic       host_valid,
    output logic [7:0] host_byte
);
    initial
    begin
        host_start = 1'b0;
        host_valid = 1'b0;
        host_byte  = 8'h00;
    end
    // listen form carries no wake-up value.
    task automatic send(input logic [7:0] b [$]);
        @(negedge clock);
        host_start = 1'b1;
        @(negedge clock);
        host_start = 1'b0;
        foreach (b[i])
        begin
            host_valid = 1'b1;
            host_byte  = b[i];
            @(negedge clock);
        end
        host_valid = 1'b0;
        host_byte  = ~host_byte;
    endtask
endmodule

// ### nhi_decoder_tb.sv
/*
 Self-checking bench for the host instruction decoder.
 Assumes the host model drives the byte port and the bench plays the RF engine.
*/
`timescale 1ns/1ps
module nhi_decoder_tb;
    logic                 clock;
    logic                 reset_n;
    logic                 host_start;
    logic                 host_valid;
    logic [7:0]           host_byte;
    logic                 rf_field;
    logic                 rf_done;
    logic [1:0]           rf_result;
    logic                 listen_active;
    logic                 listen_standby;
    nhi_pkg::nhi_listen_t listen_cfg;
    logic                 listen_end_irq;
    logic                 auth_start;
    nhi_pkg::nhi_auth_t   auth_cfg;
    logic                 second_general_timer_reserved;
    logic                 status_valid;
    logic [7:0]           status_byte;
    logic                 inv_start;
    nhi_pkg::nhi_inv_t    inv_cfg;
    logic                 select_byte_valid;
    logic [7:0]           select_byte;
    logic                 cmd_invalid;
    int                   bad_count = 0;
    int                   check_count = 0;
    int                   cnt [5];
    int                   n;
    logic [2:0]           vb;
    logic [47:0]          key;
    logic [31:0]          uid;
    logic [7:0]           sel_q [$];
    logic [7:0]           sel [$];
    logic [7:0]           q [$];

    nhi_decoder dut (.clock, .reset_n, .host_start, .host_valid, .host_byte, .rf_field, .rf_done, .rf_result,
        .listen_active, .listen_standby, .listen_cfg, .listen_end_irq, .auth_start, .auth_cfg, .second_general_timer_reserved,
        .status_valid, .status_byte, .inv_start, .inv_cfg, .select_byte_valid, .select_byte, .cmd_invalid);
    nhi_host_model u_host (.clock, .host_start, .host_valid, .host_byte);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cnt[0] += int'(auth_start === 1'b1);
        cnt[1] += int'(inv_start === 1'b1);
        cnt[2] += int'(status_valid === 1'b1);
        cnt[3] += int'(cmd_invalid === 1'b1);
        cnt[4] += int'(listen_end_irq === 1'b1);
        if (select_byte_valid === 1'b1)
            sel_q.push_back(select_byte);
    end

    // ==========================================
    // Shared tasks.
    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_for(input int k);
        for (int i = 0; i < 300 && cnt[k] == 0; i++)
            @(negedge clock);
        chk("pulse seen", 64'h1, 64'(cnt[k] != 0));
        if (cnt[k] == 0)
            give_verdict();
    endtask
    task automatic go();
        cnt = '{default: 0};
        sel_q = {};
        u_host.send(q);
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] b [$]);
        logic [15:0] c;
        c = nhi_pkg::CRC16_INIT;
        foreach (b[i])
            for (int j = 7; j >= 0; j--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? nhi_pkg::CRC16_POLY : 16'h0000);
        return c;
    endfunction
    function automatic logic [4:0] crc5(input logic [23:0] r);
        logic [4:0] c;
        c = nhi_pkg::CRC5_INIT;
        for (int j = 23; j >= 0; j--)
            c = {c[3:0], 1'b0} ^ ((c[4] ^ r[j]) ? nhi_pkg::CRC5_POLY : 5'h00);
        return c;
    endfunction

    // ==========================================
    // Main sequence.
    initial
    begin
        reset_n = 1'b0;
        rf_field = 1'b0;
        rf_done = 1'b0;
        rf_result = 2'h0;
        do_reset();
        for (int i = 0; i < 4; i++)
        begin
            key = 48'ha1b2c3d4e5f6 ^ {6{8'(i)}};
            uid = 32'h9e3c5a70 + 32'(i);
            q = {nhi_pkg::CMD_CARD_AUTH};
            for (int j = 0; j < 6; j++)
                q.push_back(key[47 - 8 * j -: 8]);
            q.push_back(i[0] ? nhi_pkg::KEY_TYPE_B : nhi_pkg::KEY_TYPE_A);
            q.push_back(8'(i * 85));
            for (int j = 0; j < 4; j++)
                q.push_back(uid[31 - 8 * j -: 8]);
            go();
            wait_for(0);
            chk("key", 64'(key), 64'(auth_cfg.key));
            chk("key b", 64'(i[0]), 64'(auth_cfg.use_key_b));
            chk("block", 64'(i * 85), 64'(auth_cfg.block));
            chk("uid", 64'(uid), 64'(auth_cfg.uid));
            @(negedge clock);
            chk("timer busy", 64'h1, 64'(second_general_timer_reserved));
            repeat (3) @(negedge clock);
            rf_result = 2'(i);
            rf_done = 1'b1;
            @(negedge clock);
            rf_done = 1'b0;
            rf_result = ~rf_result;
            wait_for(2);
            chk("status", i > 1 ? 64'h2 : 64'(i), 64'(status_byte));
            repeat (2) @(negedge clock);
            chk("timer free", 64'h0, 64'(second_general_timer_reserved));
        end
        for (int t = 0; t < 3; t++)
        begin
            n = t == 0 ? 0 : t == 1 ? 3 : 39;
            vb = t == 2 ? 3'h7 : 3'h0;
            sel = {};
            for (int j = 0; j < n; j++)
                sel.push_back(8'h30 + 8'(j));
            q = {nhi_pkg::CMD_TAG_INVENTORY, 8'(n)};
            if (n != 0)
                q = {q, 8'(vb), sel};
            q = {q, 8'ha5, 8'h0f, 8'h3c, 8'(t)};
            go();
            wait_for(1);
            chk("with select", 64'(n != 0), 64'(inv_cfg.with_select));
            chk("select len", 64'(n), 64'(inv_cfg.select_len));
            chk("round", 64'ha50f3c, 64'(inv_cfg.round));
            chk("round crc", 64'(crc5(24'ha50f3c)), 64'(inv_cfg.round_crc));
            chk("all slots", 64'(t == 0), 64'(inv_cfg.all_slots));
            chk("handle", 64'(t == 2), 64'(inv_cfg.want_handle));
            chk("select data", 64'h1, 64'(sel_q == sel));
            if (n != 0)
                chk("valid bits", 64'(vb), 64'(inv_cfg.last_bits));
            if (n == 3)
                chk("select crc", 64'(crc16(sel)), 64'(inv_cfg.select_crc));
        end
        for (int r = 0; r < 4; r++)
        begin
            case (r)
                0: q = {nhi_pkg::CMD_CARD_AUTH, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h62};
                1: q = {nhi_pkg::CMD_TAG_INVENTORY, 8'h28, 8'h00};
                2: q = {nhi_pkg::CMD_TAG_INVENTORY, 8'h00, 8'ha5, 8'h0f, 8'h3c, 8'h03};
                default: q = {nhi_pkg::CMD_SWITCH_MODE, nhi_pkg::MODE_LISTEN, 8'h01, 8'h03};
            endcase
            go();
            wait_for(3);
            repeat (16) @(negedge clock);
            chk("refused", 64'h0, 64'(cnt[0] + cnt[1] + int'(listen_active)));
        end
        for (int s = 0; s < 3; s++)
        begin
            rf_field = 1'b1;
            q = {nhi_pkg::CMD_SWITCH_MODE, nhi_pkg::MODE_LISTEN, 8'h05 << s, 8'(s)};
            go();
            repeat (4) @(negedge clock);
            chk("listen on", 64'h1, 64'(listen_active));
            chk("listen cfg", 64'({8'h05 << s, s == 0, s == 1}), 64'(listen_cfg));
            rf_field = 1'b0;
            repeat (12) @(negedge clock);
            chk("listen kept", 64'(s != 0), 64'(listen_active));
            chk("end irq", 64'(s == 0), 64'(cnt[4] != 0));
            chk("standby", 64'(s == 1), 64'(listen_standby));
            rf_field = 1'b1;
            repeat (12) @(negedge clock);
            chk("awake", 64'h0, 64'(listen_standby));
            do_reset();
        end
        give_verdict();
    end
endmodule
